// File: ac_link_frame_interface.sv
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [RULE_01] Frames start on SYNC rise, clocked by BIT_CLK
// [RULE_02] SYNC registered on following falling edge
// [RULE_03] Outgoing bits captured on falling edges
// [RULE_04] Controller sends MSB first, zero stuffed
// [RULE_05] Controller zero-fills short samples
// [RULE_06] Controller duplicates mono data both slots
// [RULE_07] Outgoing slot 0 tag bit layout
// [RULE_08] Slot 0 low bits hold codec ID
// [RULE_09] Playback pair selectable among four pairs
// [RULE_10] Outgoing slot 5 ignored
// [RULE_11] Slot 1 read flag and register index
// [RULE_12] 64 even registers, odd index selects none
// [RULE_13] All registers readable and writable
// [RULE_14] Slot 2 write data in bits 19:4
// [RULE_15] GPIO control taken from slot 12
// [RULE_16] Ready bit first, one bit per rise
// [RULE_17] Incoming MSB first, invalid bits zero
// [RULE_18] Ready bit low until operational
// [RULE_19] Ready within 400 us of SYNC
// [RULE_20] Controller waits for power bits set
// [RULE_21] Controller polls ready, then reads tags
// [RULE_22] Read answer echoes index, tags both slots
// [RULE_23] Controller holds SYNC high 16 periods
// [RULE_24] Incoming slot 1 field layout
// [RULE_25] Slot 1/2 tags only for read answers
// [RULE_26] Secondary ignores frames without frame valid
// [RULE_27] 256-bit frame, counters realign on SYNC
// [RULE_28] Secondary acts only on matching ID
module ac_link_frame_interface
    import ac_link_pkg::*;
#(
    parameter int unsigned READY_CYCLES = READY_CYCLES_DEF
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bit_clk,
    input  wire logic        sync,
    input  wire logic        sdata_out,
    output logic             sdata_in,
    output pcm_pair_t        pb_pcm,
    output logic             pb_valid,
    input  wire pcm_pair_t   rec_pcm,
    input  wire logic        rec_valid,
    output logic      [19:0] gpio_ctrl
);

    function automatic slot_pos_t pos_of(input logic [7:0] p);
        slot_pos_t   r;
        logic [7:0]  q;
        r = '0;
        q = p - TAG_BITS;
        if (p < TAG_BITS)
        begin
            r.slot    = SLOT_TAG;
            r.bit_idx = 5'(TAG_BITS - 8'h01 - p);
        end
        else
        begin
            r.slot    = 4'(q / SLOT_BITS + 8'h01);
            r.bit_idx = 5'(SLOT_BITS - 8'h01 - q % SLOT_BITS);
        end
        return r;
    endfunction

    function automatic logic [3:0] left_of(input logic [1:0] sel);
        return PAIR_SLOTS[sel][7:4];
    endfunction

    function automatic logic [3:0] right_of(input logic [1:0] sel);
        return PAIR_SLOTS[sel][3:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling and BIT_CLK edge finding.

    logic [2:0]  pins_s;
    logic        bclk_d;
    logic        sync_prev;
    logic        rise;
    logic        fall;
    logic        frame_start;
    logic        active;
    logic [7:0]  bit_pos;
    slot_pos_t   cur;

    link_sync #(.WIDTH(3)) u_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .d       ({bit_clk, sync, sdata_out}),
        .q       (pins_s)
    );

    assign rise        = ce && pins_s[2] && !bclk_d;
    assign fall        = ce && !pins_s[2] && bclk_d;
    assign frame_start = fall && pins_s[1] && !sync_prev; // [RULE_01] [RULE_02]
    assign cur         = pos_of(bit_pos);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bclk_d <= 1'b0;
        else if (ce)
            bclk_d <= pins_s[2];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_prev <= 1'b0;
            active    <= 1'b0;
            bit_pos   <= 8'h00;
        end
        else if (fall)
        begin
            sync_prev <= pins_s[1];
            if (frame_start)
            begin
                active  <= 1'b1;
                bit_pos <= 8'h00; // [RULE_27]
            end
            else
                bit_pos <= bit_pos + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outgoing frame capture.

    logic [19:0] out_shift;
    logic [19:0] nsh;
    logic [15:0] tag;
    logic [19:0] cmd_addr;
    logic [1:0]  pair_sel;
    logic [1:0]  own_id;
    logic        slot_end;
    logic        cmd_go;
    logic        reg_we;
    logic        rd_go;
    logic [15:0] reg_rdata;
    pcm_pair_t   pb_stage;
    logic        got_pb;

    assign nsh      = {out_shift[18:0], pins_s[0]};
    assign slot_end = fall && active && (cur.bit_idx == 5'h00);
    // A secondary uses its ID in place of the primary's address tag.
    assign cmd_go   = tag[TAG_FRAME] && ((own_id == ID_PRIMARY) ? tag[TAG_CMD_ADDR]
                                                                : (tag[1:0] == own_id)); // [RULE_26] [RULE_28] [RULE_08]
    assign reg_we   = slot_end && (cur.slot == SLOT_DATA) && cmd_go && !cmd_addr[CMD_READ] && !cmd_addr[12]
                      && ((own_id != ID_PRIMARY) || tag[TAG_CMD_DATA]); // [RULE_12] [RULE_07] [RULE_11]
    assign rd_go    = slot_end && (cur.slot == SLOT_DATA) && cmd_go && cmd_addr[CMD_READ];

    codec_regfile u_regs
    (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .we      (reg_we),
        .addr    (cmd_addr[18:13]),
        .wdata   (nsh[19:4]),
        .rdata   (reg_rdata)
    ); // [RULE_13] [RULE_14]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_shift <= 20'h00000;
            tag       <= 16'h0000;
            cmd_addr  <= 20'h00000;
        end
        else if (fall && active)
        begin
            out_shift <= nsh; // [RULE_03]
            if (slot_end && (cur.slot == SLOT_TAG))
                tag <= nsh[15:0];
            if (slot_end && (cur.slot == SLOT_ADDR))
                cmd_addr <= nsh;
        end
    end

    // Playback is staged so that both halves appear together.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pb_stage  <= '0;
            got_pb    <= 1'b0;
            pb_pcm    <= '0;
            pb_valid  <= 1'b0;
            gpio_ctrl <= 20'h00000;
        end
        else if (ce)
        begin
            pb_valid <= 1'b0;
            if (slot_end && tag[TAG_FRAME] && (cur.slot != SLOT_MODEM)) // [RULE_10]
            begin
                if ((cur.slot == left_of(pair_sel)) && tag[TAG_FRAME - int'(cur.slot)]) // [RULE_09]
                begin
                    pb_stage.left <= nsh;
                    got_pb        <= 1'b1;
                end
                if ((cur.slot == right_of(pair_sel)) && tag[TAG_FRAME - int'(cur.slot)])
                begin
                    pb_stage.right <= nsh;
                    got_pb         <= 1'b1;
                end
                if ((cur.slot == SLOT_GPIO) && tag[TAG_FRAME - int'(SLOT_GPIO)])
                    gpio_ctrl <= nsh; // [RULE_15]
            end
            if (slot_end && (cur.slot == SLOT_GPIO))
            begin
                pb_valid <= got_pb;
                pb_pcm   <= pb_stage;
                got_pb   <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read answers and readiness.

    logic        pend;
    logic [6:0]  pend_idx;
    logic [15:0] pend_data;
    logic        resp_valid;
    logic [6:0]  resp_idx;
    logic [15:0] resp_data;
    logic [31:0] rdy_cnt;
    logic        link_ready;
    pcm_pair_t   cap_pcm;
    logic        cap_valid;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend       <= 1'b0;
            pend_idx   <= 7'h00;
            pend_data  <= 16'h0000;
            resp_valid <= 1'b0;
            resp_idx   <= 7'h00;
            resp_data  <= 16'h0000;
            cap_pcm    <= '0;
            cap_valid  <= 1'b0;
        end
        else if (ce)
        begin
            if (frame_start)
            begin
                resp_valid <= pend; // [RULE_25]
                resp_idx   <= pend_idx;
                resp_data  <= pend_data;
                pend       <= 1'b0;
                cap_pcm    <= rec_pcm;
                cap_valid  <= rec_valid;
            end
            // A read latched in the cycle of a frame start must not be lost, so the set comes last and wins.
            if (rd_go)
            begin
                pend      <= 1'b1;
                pend_idx  <= cmd_addr[18:12];
                pend_data <= cmd_addr[12] ? 16'h0000 : reg_rdata; // [RULE_12]
            end
        end
    end

    // The deadline is counted from the first frame start seen.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdy_cnt    <= 32'h00000000;
            link_ready <= 1'b0;
        end
        else if (ce && active && !link_ready)
        begin
            rdy_cnt <= rdy_cnt + 32'h00000001;
            if (rdy_cnt == READY_CYCLES - 1)
                link_ready <= 1'b1; // [RULE_19] [RULE_18]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Incoming frame generation.

    logic [15:0] tag_in;
    logic [19:0] in_word;

    always_comb
    begin
        tag_in                              = 16'h0000;
        tag_in[TAG_FRAME]                   = link_ready;
        tag_in[TAG_CMD_ADDR]                = resp_valid; // [RULE_22]
        tag_in[TAG_CMD_DATA]                = resp_valid;
        tag_in[TAG_FRAME - int'(left_of(pair_sel))]  = cap_valid;
        tag_in[TAG_FRAME - int'(right_of(pair_sel))] = cap_valid;
        in_word = 20'h00000; // [RULE_17]
        if (cur.slot == SLOT_TAG)
            in_word = {4'h0, tag_in};
        else if ((cur.slot == SLOT_ADDR) && resp_valid)
            in_word = {1'b0, resp_idx, 12'h000}; // [RULE_24]
        else if ((cur.slot == SLOT_DATA) && resp_valid)
            in_word = {resp_data, 4'h0};
        else if ((cur.slot == left_of(pair_sel)) && cap_valid)
            in_word = cap_pcm.left;
        else if ((cur.slot == right_of(pair_sel)) && cap_valid)
            in_word = cap_pcm.right;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sdata_in <= 1'b0;
        else if (rise)
            sdata_in <= active ? in_word[cur.bit_idx] : 1'b0; // [RULE_16]
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave; no wait states, so pready is fixed high.

    logic mapped;

    assign pready  = 1'b1;
    assign mapped  = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_GPIO);
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pair_sel <= PAIR_RESET;
            own_id   <= ID_PRIMARY;
        end
        else if (ce && psel && penable && pwrite && (paddr == ADDR_CTRL))
        begin
            pair_sel <= pwdata[CTRL_PAIR_LO +: 2];
            own_id   <= pwdata[CTRL_ID_LO +: 2];
        end
    end

    // Read data is loaded in the setup cycle so it is stable in the access cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (ce && psel && !penable)
        begin
            prdata <= 32'h00000000;
            if (paddr == ADDR_CTRL)
                prdata <= {28'h0000000, own_id, pair_sel};
            else if (paddr == ADDR_STATUS)
                prdata <= {29'h00000000, pend, active, link_ready};
            else if (paddr == ADDR_GPIO)
                prdata <= {12'h000, gpio_ctrl};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_frame_detect;
        fall && pins_s[1] && !sync_prev;
    endsequence

    a_frame_realign: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_27]
        s_frame_detect |=> (bit_pos == 8'h00) && active)
        else $error("bit counter not realigned at frame start");

    a_ready_bit_first: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_16]
        (rise && active && (bit_pos == 8'h00)) |=> (sdata_in == $past(link_ready)))
        else $error("first incoming bit is not the ready flag");

    a_ready_deadline: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_19]
        (ce && active && (rdy_cnt == READY_CYCLES - 1)) |=> link_ready)
        else $error("ready not raised at deadline");

    a_not_ready_idle: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_18]
        !active |-> !link_ready)
        else $error("ready raised before any frame");

    a_odd_write_blocked: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_12]
        reg_we |-> !cmd_addr[12] && !cmd_addr[CMD_READ])
        else $error("write to odd index or on read command");

    a_secondary_match: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_28]
        (reg_we || rd_go) && (own_id != ID_PRIMARY) |-> tag[TAG_FRAME] && (tag[1:0] == own_id))
        else $error("secondary acted on foreign or invalid frame");

    a_resp_tags: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_25]
        (rise && active && (bit_pos == 8'h01)) |=> (sdata_in == resp_valid))
        else $error("slot 1 tag does not follow read answer");

    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_17]
        (rise && ((cur.slot == SLOT_MODEM) || (cur.slot == SLOT_GPIO))) |=> !sdata_in)
        else $error("unused incoming slot not zero");

    a_read_answered: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_22]
        (s_frame_detect and pend) |=> resp_valid && (resp_idx == $past(pend_idx)))
        else $error("read answer lost or index changed");

endmodule
`default_nettype wire

// File: ac_link_pkg.sv
`default_nettype none
package ac_link_pkg;

    // Register map of the bus side.
    localparam logic [11:0] ADDR_CTRL    = 12'h000;
    localparam logic [11:0] ADDR_STATUS  = 12'h004;
    localparam logic [11:0] ADDR_GPIO    = 12'h008;
    localparam int          CTRL_PAIR_LO = 0;
    localparam int          CTRL_ID_LO   = 2;
    localparam int          STAT_READY   = 0;
    localparam int          STAT_ACTIVE  = 1;
    localparam int          STAT_PEND    = 2;
    localparam logic [1:0]  PAIR_RESET   = 2'h0;
    localparam logic [1:0]  ID_PRIMARY   = 2'h0;

    // Frame layout.
    localparam logic [7:0]  TAG_BITS     = 8'h10;
    localparam logic [7:0]  SLOT_BITS    = 8'h14;
    localparam int          TAG_FRAME    = 15;
    localparam int          TAG_CMD_ADDR = 14;
    localparam int          TAG_CMD_DATA = 13;
    localparam int          CMD_READ     = 19;
    localparam logic [3:0]  SLOT_TAG     = 4'h0;
    localparam logic [3:0]  SLOT_ADDR    = 4'h1;
    localparam logic [3:0]  SLOT_DATA    = 4'h2;
    localparam logic [3:0]  SLOT_MODEM   = 4'h5;
    localparam logic [3:0]  SLOT_GPIO    = 4'hc;

    // Left slot in the high nibble, right slot in the low nibble.
    localparam logic [7:0]  PAIR_SLOTS [4] = '{8'h34, 8'h69, 8'h78, 8'hab};

    // Ready deadline after the first frame start.
    localparam int unsigned READY_TIME_US    = 400;
    localparam int unsigned CLK_MHZ          = 50;
    localparam int unsigned READY_CYCLES_DEF = READY_TIME_US * CLK_MHZ;

    typedef struct packed {
        logic [19:0] left;
        logic [19:0] right;
    } pcm_pair_t;

    typedef struct packed {
        logic [3:0] slot;
        logic [4:0] bit_idx;
    } slot_pos_t;

endpackage
`default_nettype wire

// File: link_sync.sv
`timescale 1ns/100ps
`default_nettype none
module link_sync
#(
    parameter int WIDTH = 3
)
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    // The first stage feeds only the second stage.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta <= '0;
            q    <= '0;
        end
        else if (ce)
        begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule
`default_nettype wire

// File: codec_regfile.sv
`timescale 1ns/100ps
`default_nettype none
module codec_regfile
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        we,
    input  wire logic [5:0]  addr,
    input  wire logic [15:0] wdata,
    output logic      [15:0] rdata
);

    logic [15:0] mem [64];

    genvar i;
    generate
        for (i = 0; i < 64; i++)
        begin : g_word
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    mem[i] <= 16'h0000;
                else if (ce && we && (addr == 6'(i)))
                    mem[i] <= wdata;
            end
        end
    endgenerate

    assign rdata = mem[addr];

endmodule
`default_nettype wire

// File: ac_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none
module ac_ctl_model
(
    output logic bit_clk,
    output logic sync,
    output logic sdata_out,
    input  wire logic sdata_in
);
    initial
    begin
        bit_clk = 1'b0;
        forever #80 bit_clk = ~bit_clk;
    end

    initial
    begin
        sync = 1'b0;
        sdata_out = 1'b0;
    end

    ////////////////////////////////////////
    // One extra rise opens each frame to raise SYNC a bit period before the first outgoing
    // bit; the price is one idle bit period between back-to-back frames.
    task automatic xfer(input logic [255:0] o, output logic [255:0] i);
        for (int j = 0; j <= 256; j++)
        begin
            @(posedge bit_clk);
            sync <= (j < 16);
            sdata_out <= (j == 0) ? ~sdata_out : o[256 - j];
            @(negedge bit_clk);
            if (j > 0)
                i[256 - j] = sdata_in;
        end
    endtask
endmodule
`default_nettype wire

// File: ac_link_frame_interface_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ac_link_frame_interface_tb_top
    import ac_link_pkg::*;
;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic         bit_clk, sync, sdata_out, sdata_in, pb_valid, rec_valid, pend;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, q;
    logic [19:0]  gpio_ctrl, exp_gpio;
    logic [19:0]  os [13];
    logic [15:0]  regs [64];
    logic [15:0]  wd;
    logic [6:0]   idx, pidx;
    logic [255:0] fi, ef;
    logic [39:0]  got_pb [$];
    pcm_pair_t    pb_pcm, rec_pcm;
    int           err_count, tests_run, cyc, seed, nfr, own_id, l, r;

    ac_link_frame_interface #(.READY_CYCLES(200)) u_ac_link_frame_interface
    (
        .pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .bit_clk, .sync, .sdata_out, .sdata_in, .pb_pcm, .pb_valid, .rec_pcm, .rec_valid, .gpio_ctrl
    );

    ac_ctl_model u_ac_ctl_model (.bit_clk, .sync, .sdata_out, .sdata_in);

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (pb_valid === 1'b1)
            got_pb.push_back(pb_pcm);
        if (cyc == 70000)
        begin
            err_count++;
            end_of_test();
        end
    end

    ////////////////////////////////////////
    task automatic end_of_test();
        $display("Compared %0d, mismatched %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic cmp_frame(input logic [255:0] g, input logic [255:0] x);
        tests_run++;
        if (g !== x)
        begin
            err_count++;
            $display("ERROR %0t frame %h exp %h", $time, g, x);
        end
    endtask

    task automatic cmp_val(input logic [63:0] g, input logic [63:0] x);
        tests_run++;
        if (g !== x)
        begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, g, x);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [255:0] put(logic [255:0] f, int n, logic [19:0] v);
        f[239 - 20 * (n - 1) -: 20] = v;
        return f;
    endfunction

    // Runs one frame and checks everything it should have changed against the model state.
    task automatic xf(input logic [15:0] tag);
        logic [255:0] fo;
        int           x;
        fo = {tag, 240'h0};
        ef = {nfr > 0, 255'h0};
        for (int n = 1; n <= 12; n++)
            if (tag[15 - n] || (n < 3 && tag[1:0] != 2'h0))
                fo = put(fo, n, os[n]);
        if (pend)
        begin
            ef[254:253] = 2'b11;
            ef = put(ef, 1, {1'b0, pidx, 12'h0});
            ef = put(ef, 2, {pidx[0] ? 16'h0 : regs[pidx[6:1]], 4'h0});
        end
        if (rec_valid)
        begin
            ef[255 - l] = 1'b1;
            ef[255 - r] = 1'b1;
            ef = put(ef, l, rec_pcm.left);
            ef = put(ef, r, rec_pcm.right);
        end
        u_ac_ctl_model.xfer(fo, fi);
        cmp_frame(fi, ef);
        nfr++;
        pend = 1'b0;
        if (tag[15] && (own_id == 0 ? tag[14] : tag[1:0] == 2'(own_id)))
        begin
            pidx = os[1][18:12];
            pend = os[1][19];
            if (!pend && (own_id != 0 || tag[13]) && !pidx[0])
                regs[pidx[6:1]] = os[2][19:4];
        end
        x = tag[15] && tag[15 - l];
        for (int k = 0; k < 24 && got_pb.size() == 0; k++)
            @(posedge pclk);
        cmp_val(got_pb.size(), x);
        if (x && got_pb.size() > 0)
            cmp_val(got_pb.pop_front(), {os[l], os[r]});
        got_pb.delete();
        if (tag[15] && tag[3])
            exp_gpio = os[12];
        cmp_val(gpio_ctrl, exp_gpio);
        apb(1'b0, ADDR_STATUS, 32'h0);
        cmp_val(q, {pend, 2'b11});
        apb(1'b0, ADDR_GPIO, 32'h0);
        cmp_val(q, exp_gpio);
    endtask

    ////////////////////////////////////////
    initial
    begin
        seed = 32'h93064335;
        {presetn, psel, penable, pwrite, paddr, pwdata, rec_valid, rec_pcm, pend, exp_gpio} = '0;
        foreach (regs[i])
            regs[i] = 16'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h00c, 32'h0);
        cmp_val({e, q}, 33'h100000000);
        apb(1'b0, ADDR_STATUS, 32'h0);
        cmp_val(q, 32'h0);
        l = 3;
        r = 4;
        // Commands wait until the codec has reported ready in an incoming frame.
        xf(16'h0);
        xf(16'h0);
        for (int p = 0; p < 4; p++)
        begin
            l = PAIR_SLOTS[p][7:4];
            r = PAIR_SLOTS[p][3:0];
            apb(1'b1, ADDR_CTRL, 32'(p));
            apb(1'b0, ADDR_CTRL, 32'h0);
            cmp_val(q, p);
            rec_pcm <= 40'({$random(seed), $random(seed)});
            rec_valid <= 1'b1;
            // The reference reads the record inputs at once, so let the new values land first.
            @(posedge pclk);
            idx = 7'($random(seed));
            idx[0] = (p == 3);
            wd = 16'($random(seed));
            for (int s = 0; s < 3; s++)
            begin
                for (int n = 1; n <= 12; n++)
                    os[n] = 20'($random(seed));
                if (p == 1)
                    os[r] = os[l];
                if (p == 2)
                    os[l][11:0] = 12'h0;
                os[1] = {s == 1, idx, 12'h0};
                os[2] = (s == 0) ? {wd, 4'h0} : 20'h0;
                xf((s == 0 ? 16'he000 : s == 1 ? 16'hc000 : 16'h8000) | 16'h0408 | (16'h8000 >> l) | (16'h8000 >> r));
            end
        end
        l = 3;
        r = 4;
        own_id = 2;
        apb(1'b1, ADDR_CTRL, 32'h8);
        rec_valid <= 1'b0;
        @(posedge pclk);
        idx = 7'($random(seed)) & 7'h7e;
        for (int s = 0; s < 5; s++)
        begin
            os[1] = {s == 3, idx, 12'h0};
            os[2] = (s == 3) ? 20'h0 : {wd + 16'(s), 4'h0};
            xf(s == 0 ? 16'h0002 : s == 1 ? 16'h8001 : s < 4 ? 16'h8002 : 16'h8000);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
